/* File: rtl/tmv_timer.sv */
// 8-bit trigger timer with two compares, waveform output, apb registers
// assumes pins arrive asynchronous to core_clk; clear pulses >= 1.5 clocks
//
// How it works
// - reserved trigger bits 7-5 and 1 read one
// - edge field selects none, rise, fall, both
// - trigger mode runs at once, halts on clear, edge restarts
// - low select bit joins three select bits
// - six divided internal, three external, four codes off
// - counting begins once a source is selected
// - wrap to zero sets overflow flag, irq
// - flag cleared by zero after read as one
// - compare continuously, match sets compare flag
// - enabled compare flags raise interrupt
// - compare drives waveform per select field
// - output select none, low, high, toggle
// - waveform low after reset until compare
// - clear select one/two clear on A/B
// - clear select three uses clear pin rise
// - trigger mode stops after clear, edge resumes
// - clear beats cpu counter write
// - cpu counter write beats increment
// - compare register write suppresses compare event
// - simultaneous actions: toggle, high, then low
// - falling edge of divided clock increments
// - source switch may add one increment
// - clear on A gives free periodic pulse
// - trigger plus clear on B gives one pulse
`timescale 1ns/100ps
module tmv_timer (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic extClockPin,
  input wire logic trigger_input_pin,
  input wire logic external_clear_pin,
  output logic waveform_output_pin,
  output logic irqRequest
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0] syncA_q, syncA_d, syncB_q, syncB_d, last_q, last_d;
  always_comb
  begin
    syncA_d = {extClockPin, trigger_input_pin, external_clear_pin};
    syncB_d = syncA_q;
    last_d = syncB_q;
  end
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      syncA_q <= 3'h0;
      syncB_q <= 3'h0;
      last_q <= 3'h0;
    end
    else if (clkEn)
    begin
      syncA_q <= syncA_d;
      syncB_q <= syncB_d;
      last_q <= last_d;
    end
  end
  logic extRise, extFall, trgRise, trgFall, clrRise;
  assign extRise = syncB_q[2] & ~last_q[2];
  assign extFall = ~syncB_q[2] & last_q[2];
  assign trgRise = syncB_q[1] & ~last_q[1];
  assign trgFall = ~syncB_q[1] & last_q[1];
  assign clrRise = syncB_q[0] & ~last_q[0];

  // ****************************************
  // registers
  // ****************************************
  tmv_pkg::tmv_ctrl0_s ctrl0_q, ctrl0_d;
  tmv_pkg::tmv_trig_s trig_q, trig_d;
  tmv_pkg::tmv_flags_s flags_q, flags_d, seen_q, seen_d;
  logic [3:0] outSel_q, outSel_d;
  logic [7:0] cmpA_q, cmpA_d, cmpB_q, cmpB_d, cnt_q, cnt_d;
  logic [6:0] div_q, div_d;
  logic srcLevel_q, srcLevel_d, halted_q, halted_d, wave_q, wave_d;
  logic rdWait_q, rdWait_d;
  logic [31:0] rdata_q, rdata_d;

  logic access, wrEn, rdEn, mapped;
  logic wrCtrl0, wrCsr, wrCmpA, wrCmpB, wrCnt, wrTrig;
  logic [7:0] wbyte;
  assign access = psel & penable & clkEn;
  assign wrEn = access & pwrite;
  assign rdEn = access & ~pwrite & ~rdWait_q;
  assign wbyte = pwdata[7:0];
  always_comb
  begin
    wrCtrl0 = 1'b0;
    wrCsr = 1'b0;
    wrCmpA = 1'b0;
    wrCmpB = 1'b0;
    wrCnt = 1'b0;
    wrTrig = 1'b0;
    mapped = 1'b1;
    if (paddr[31:0] == {24'h0, tmv_pkg::OFF_CTRL0})
      wrCtrl0 = wrEn;
    else if (paddr[31:0] == {24'h0, tmv_pkg::OFF_CSR})
      wrCsr = wrEn;
    else if (paddr[31:0] == {24'h0, tmv_pkg::OFF_CMPA})
      wrCmpA = wrEn;
    else if (paddr[31:0] == {24'h0, tmv_pkg::OFF_CMPB})
      wrCmpB = wrEn;
    else if (paddr[31:0] == {24'h0, tmv_pkg::OFF_CNT})
      wrCnt = wrEn;
    else if (paddr[31:0] == {24'h0, tmv_pkg::OFF_TRIG})
      wrTrig = wrEn;
    else
      mapped = 1'b0;
  end

  // ****************************************
  // read wait state
  // ****************************************
  // one wait cycle on reads: registered data stands at the ready edge
  logic rdFirst;
  assign rdFirst = psel & penable & ~pwrite & ~rdWait_q;

  // ****************************************
  // clock source selection
  // ****************************************
  logic [3:0] code;
  logic srcLevel, internalSrc, tick;
  assign code = {ctrl0_q.clockSelect, trig_q.clockSelectLow};
  // divider tap n runs at the core clock divided by two to the n+1
  always_comb
  begin
    srcLevel = 1'b0;
    internalSrc = 1'b1;
    tick = 1'b0;
    case (code)
      4'h2: srcLevel = div_q[1];
      4'h3: srcLevel = div_q[2];
      4'h4: srcLevel = div_q[3];
      4'h5: srcLevel = div_q[4];
      4'h6: srcLevel = div_q[5];
      4'h7: srcLevel = div_q[6];
      4'ha, 4'hb:
      begin
        internalSrc = 1'b0;
        tick = extRise;
      end
      4'hc, 4'hd:
      begin
        internalSrc = 1'b0;
        tick = extFall;
      end
      4'he, 4'hf:
      begin
        internalSrc = 1'b0;
        tick = extRise | extFall;
      end
      default: internalSrc = 1'b1;
    endcase
    if (internalSrc)
      tick = srcLevel_q & ~srcLevel;
    else
      srcLevel = 1'b0;
  end

  // ****************************************
  // compare, clear, count
  // ****************************************
  logic matchA, matchB, cmpEvA, cmpEvB, clearEv, trigEdge, incr;
  assign matchA = (cnt_q == cmpA_q);
  assign matchB = (cnt_q == cmpB_q);
  // event in last state of equality: next increment leaves the value
  assign cmpEvA = matchA & incr & ~wrCmpA;
  assign cmpEvB = matchB & incr & ~wrCmpB;
  always_comb
  begin
    case (ctrl0_q.clearSelect)
      tmv_pkg::SEL_LO: clearEv = cmpEvA;
      tmv_pkg::SEL_HI: clearEv = cmpEvB;
      tmv_pkg::SEL_BOTH: clearEv = clrRise;
      default: clearEv = 1'b0;
    endcase
    case (trig_q.edgeSelect)
      tmv_pkg::SEL_LO: trigEdge = trgRise;
      tmv_pkg::SEL_HI: trigEdge = trgFall;
      tmv_pkg::SEL_BOTH: trigEdge = trgRise | trgFall;
      default: trigEdge = 1'b0;
    endcase
  end
  assign incr = tick & ~(trig_q.trigModeEnable & halted_q);

  logic [2:0] act;
  always_comb
  begin
    div_d = div_q + 7'h01;
    srcLevel_d = srcLevel;
    cnt_d = cnt_q;
    if (clearEv)
      cnt_d = 8'h00;
    else if (wrCnt)
      cnt_d = wbyte;
    else if (incr)
      cnt_d = cnt_q + 8'h01;
    halted_d = halted_q;
    if (!trig_q.trigModeEnable)
      halted_d = 1'b0;
    else if (clearEv)
      halted_d = 1'b1;
    else if (trigEdge)
      halted_d = 1'b0;
    // output action priority toggle > high > low
    act = {(cmpEvA & outSel_q[1:0] == tmv_pkg::SEL_BOTH)
             | (cmpEvB & outSel_q[3:2] == tmv_pkg::SEL_BOTH),
           (cmpEvA & outSel_q[1:0] == tmv_pkg::SEL_HI)
             | (cmpEvB & outSel_q[3:2] == tmv_pkg::SEL_HI),
           (cmpEvA & outSel_q[1:0] == tmv_pkg::SEL_LO)
             | (cmpEvB & outSel_q[3:2] == tmv_pkg::SEL_LO)};
    if (act[2])
      wave_d = ~wave_q;
    else if (act[1])
      wave_d = 1'b1;
    else if (act[0])
      wave_d = 1'b0;
    else
      wave_d = wave_q;
  end

  // ****************************************
  // register writes and flags
  // ****************************************
  logic rdCsr;
  assign rdCsr = rdEn & (paddr[31:0] == {24'h0, tmv_pkg::OFF_CSR});
  always_comb
  begin
    ctrl0_d = wrCtrl0 ? tmv_pkg::tmv_ctrl0_s'(wbyte) : ctrl0_q;
    trig_d = wrTrig ? tmv_pkg::tmv_trig_s'({wbyte[4:2], wbyte[0]}) : trig_q;
    outSel_d = wrCsr ? wbyte[3:0] : outSel_q;
    cmpA_d = wrCmpA ? wbyte : cmpA_q;
    cmpB_d = wrCmpB ? wbyte : cmpB_q;
    flags_d = flags_q;
    seen_d = seen_q;
    if (rdCsr)
      seen_d = flags_q;
    if (wrCsr)
    begin
      // zero clears only a flag seen as one
      flags_d = flags_q & ~(seen_q & ~tmv_pkg::tmv_flags_s'(wbyte[7:5]));
      seen_d = '0;
    end
    if (cmpEvB)
      flags_d.cmpBFlag = 1'b1;
    if (cmpEvA)
      flags_d.cmpAFlag = 1'b1;
    if (incr & ~clearEv & ~wrCnt & (cnt_q == 8'hff))
      flags_d.ovfFlag = 1'b1;
  end

  // ****************************************
  // read mux
  // ****************************************
  always_comb
  begin
    rdWait_d = rdFirst;
    rdata_d = rdata_q;
    if (rdEn)
    begin
      rdata_d = 32'h0;
      if (paddr[31:0] == {24'h0, tmv_pkg::OFF_CTRL0})
        rdata_d[7:0] = ctrl0_q;
      else if (paddr[31:0] == {24'h0, tmv_pkg::OFF_CSR})
        rdata_d[7:0] = {flags_q, 1'b0, outSel_q} | tmv_pkg::CSR_ONES;
      else if (paddr[31:0] == {24'h0, tmv_pkg::OFF_CMPA})
        rdata_d[7:0] = cmpA_q;
      else if (paddr[31:0] == {24'h0, tmv_pkg::OFF_CMPB})
        rdata_d[7:0] = cmpB_q;
      else if (paddr[31:0] == {24'h0, tmv_pkg::OFF_CNT})
        rdata_d[7:0] = cnt_q;
      else if (paddr[31:0] == {24'h0, tmv_pkg::OFF_TRIG})
        rdata_d[7:0] = {3'h0, trig_q.edgeSelect, trig_q.trigModeEnable, 1'b0,
                        trig_q.clockSelectLow} | tmv_pkg::TRIG_ONES;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ctrl0_q <= '0;
      trig_q <= '0;
      flags_q <= '0;
      seen_q <= '0;
      outSel_q <= 4'h0;
      cmpA_q <= tmv_pkg::CMP_RST;
      cmpB_q <= tmv_pkg::CMP_RST;
      cnt_q <= 8'h00;
      div_q <= 7'h00;
      srcLevel_q <= 1'b0;
      halted_q <= 1'b0;
      wave_q <= 1'b0;
      rdata_q <= 32'h0;
      rdWait_q <= 1'b0;
    end
    else if (clkEn)
    begin
      ctrl0_q <= ctrl0_d;
      trig_q <= trig_d;
      flags_q <= flags_d;
      seen_q <= seen_d;
      outSel_q <= outSel_d;
      cmpA_q <= cmpA_d;
      cmpB_q <= cmpB_d;
      cnt_q <= cnt_d;
      div_q <= div_d;
      srcLevel_q <= srcLevel_d;
      halted_q <= halted_d;
      wave_q <= wave_d;
      rdata_q <= rdata_d;
      rdWait_q <= rdWait_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata = rdata_q;
  // writes answer at once; a frozen clock holds every answer off
  assign pready = clkEn & ~rdFirst;
  assign pslverr = psel & penable & ~mapped;
  assign waveform_output_pin = wave_q;
  assign irqRequest = (flags_q.ovfFlag & ctrl0_q.ovfIrqEnable)
    | (flags_q.cmpAFlag & ctrl0_q.cmpAIrqEnable)
    | (flags_q.cmpBFlag & ctrl0_q.cmpBIrqEnable);
endmodule

/* File: rtl/tmv_pkg.sv */
// package for the 8-bit trigger timer: register map, fields, codes
// assumes a 32-bit apb slave, one word per register
package tmv_pkg;
  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] OFF_CTRL0 = 8'h00;
  localparam logic [7:0] OFF_CSR = 8'h04;
  localparam logic [7:0] OFF_CMPA = 8'h08;
  localparam logic [7:0] OFF_CMPB = 8'h0c;
  localparam logic [7:0] OFF_CNT = 8'h10;
  localparam logic [7:0] OFF_TRIG = 8'h14;
  // ****************************************
  // reset values and fixed bits
  // ****************************************
  localparam logic [7:0] CMP_RST = 8'hff;
  localparam logic [7:0] TRIG_ONES = 8'he2;
  localparam logic [7:0] CSR_ONES = 8'h10;
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_LO = 2'h1;
  localparam logic [1:0] SEL_HI = 2'h2;
  localparam logic [1:0] SEL_BOTH = 2'h3;
  localparam logic [6:0] DIV_W = 7'h7f;
  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic cmpBIrqEnable;
    logic cmpAIrqEnable;
    logic ovfIrqEnable;
    logic [1:0] clearSelect;
    logic [2:0] clockSelect;
  } tmv_ctrl0_s;
  typedef struct packed {
    logic [1:0] edgeSelect;
    logic trigModeEnable;
    logic clockSelectLow;
  } tmv_trig_s;
  typedef struct packed {
    logic cmpBFlag;
    logic cmpAFlag;
    logic ovfFlag;
  } tmv_flags_s;
endpackage

/* File: bench/tmv_timer_props.sv */
// port checker for tmv_timer
// assumes one clock domain, rst synchronous active high
`timescale 1ns/100ps
module tmv_timer_props (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic waveform_output_pin,
  input wire logic irqRequest
);
  // ****
  // properties
  // ****
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic acc;
  assign acc = psel && penable && clkEn;
  wave_reset_a: assert property ($fell(rst) |-> !waveform_output_pin)
    else $error("waveform high after reset");
  irq_reset_a: assert property ($fell(rst) |-> !irqRequest)
    else $error("irq high after reset");
  trig_ones_a: assert property (acc && !pwrite && paddr[7:0] == tmv_pkg::OFF_TRIG
    |=> prdata[7:5] == 3'h7 && prdata[1])
    else $error("reserved trigger bits not one");
  wave_frozen_a: assert property (!clkEn |=> $stable(waveform_output_pin))
    else $error("waveform moved while frozen");
  irq_frozen_a: assert property (!clkEn |=> $stable(irqRequest))
    else $error("irq moved while frozen");
  irq_off_a: assert property (acc && pwrite && paddr[7:0] == tmv_pkg::OFF_CTRL0
    && pwdata[7:5] == 3'h0 |=> !irqRequest)
    else $error("irq with enables off");
  ready_high_a: assert property (psel && penable && pwrite |-> pready == clkEn)
    else $error("write not answered at once");
  read_wait_a: assert property (acc && !pwrite && !$past(penable) |-> !pready)
    else $error("read answered without wait cycle");
  bad_addr_a: assert property (acc && paddr[7:0] > tmv_pkg::OFF_TRIG |-> pslverr)
    else $error("no error on unmapped access");
  upper_zero_a: assert property (prdata[31:8] == 24'h0)
    else $error("upper read bits set");
endmodule
bind tmv_timer tmv_timer_props chk (.core_clk, .rst, .clkEn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .waveform_output_pin,
  .irqRequest);

/* File: bench/tmv_pin_model.sv */
// pin-side model: external count clock, trigger and clear sources
// assumes tasks are called just after a core_clk rising edge
`timescale 1ns/100ps
module tmv_pin_model (
  input wire logic core_clk,
  output logic extClk,
  output logic trig,
  output logic clr
);
  // ****
  // pin drivers
  // ****
  initial
  begin
    extClk = 1'b0;
    trig = 1'b0;
    clr = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic clocks(input int n);
    repeat (n)
    begin
      extClk <= 1'b1;
      hold(4);
      extClk <= 1'b0;
      hold(4);
    end
  endtask
  task automatic trigPulse();
    trig <= 1'b1;
    hold(4);
    trig <= 1'b0;
    hold(4);
  endtask
  task automatic clearPulse();
    clr <= 1'b1;
    hold(3);
    clr <= 1'b0;
    hold(3);
  endtask
endmodule

/* File: bench/tb.sv */
// self-checking bench for tmv_timer over apb
// assumes tmv_pkg offsets, pin model and bound checker
`timescale 1ns/100ps
module tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic clkEn = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, wave, irq, extClk, trig, clr;
  int n_mismatch = 0;
  int checks_done = 0;
  int c;
  always #5 core_clk = ~core_clk;
  tmv_timer uut (.core_clk, .rst, .clkEn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .extClockPin(extClk),
    .trigger_input_pin(trig), .external_clear_pin(clr),
    .waveform_output_pin(wave), .irqRequest(irq));
  tmv_pin_model pins (.core_clk, .extClk, .trig, .clr);
  // ****
  // shared tasks
  // ****
  task automatic print_verdict();
    if (n_mismatch == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic expire();
    n_mismatch++;
    $display("unexpected at %0t: wait expired", $time);
    print_verdict();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {24'h0, a};
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16)
      expire();
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic waitSig(input logic sel, input logic lvl);
    c = 0;
    while ((sel ? irq : wave) !== lvl)
    begin
      @(posedge core_clk);
      c++;
      if (c > 2000)
        expire();
    end
  endtask
  // ****
  // scenarios
  // ****
  task automatic sReset();
    chk(wave, 0);
    apb(0, tmv_pkg::OFF_TRIG, 0);
    chk(q, 32'he2);
    apb(1, tmv_pkg::OFF_TRIG, 8'h1d);
    apb(0, tmv_pkg::OFF_TRIG, 0);
    chk(q, 32'hff);
    apb(1, tmv_pkg::OFF_TRIG, 8'h00);
    apb(0, tmv_pkg::OFF_CMPA, 0);
    chk(q, 32'hff);
    apb(0, 8'h18, 0);
    chk(q, 32'h0);
  endtask
  task automatic sOverflow();
    apb(1, tmv_pkg::OFF_CNT, 8'hfe);
    apb(1, tmv_pkg::OFF_CTRL0, 8'h21);
    waitSig(1, 1);
    apb(1, tmv_pkg::OFF_CSR, 0);
    chk(irq, 1);
    apb(0, tmv_pkg::OFF_CSR, 0);
    chk(q & 32'h20, 32'h20);
    apb(1, tmv_pkg::OFF_CSR, 0);
    chk(irq, 0);
    apb(1, tmv_pkg::OFF_CTRL0, 0);
  endtask
  task automatic sPeriodic();
    logic w;
    apb(1, tmv_pkg::OFF_CMPA, 5);
    apb(1, tmv_pkg::OFF_CMPB, 1);
    apb(1, tmv_pkg::OFF_CSR, 8'h06);
    apb(1, tmv_pkg::OFF_CNT, 0);
    apb(1, tmv_pkg::OFF_CTRL0, 8'h09);
    waitSig(0, 1);
    waitSig(0, 0);
    chk(c, 8);
    waitSig(0, 1);
    chk(c, 16);
    clkEn <= 1'b0;
    tick(12);
    clkEn <= 1'b1;
    apb(1, tmv_pkg::OFF_CMPB, 5);
    apb(1, tmv_pkg::OFF_CSR, 8'h07);
    w = wave;
    waitSig(0, ~w);
    waitSig(0, w);
    chk(c, 24);
    apb(1, tmv_pkg::OFF_CTRL0, 0);
  endtask
  task automatic sTrigger();
    apb(1, tmv_pkg::OFF_CMPA, 1);
    apb(1, tmv_pkg::OFF_CMPB, 3);
    apb(1, tmv_pkg::OFF_CSR, 8'h06);
    apb(1, tmv_pkg::OFF_TRIG, 8'h04);
    apb(1, tmv_pkg::OFF_CNT, 0);
    apb(1, tmv_pkg::OFF_CTRL0, 8'h11);
    for (int e = 0; e < 4; e++)
    begin
      apb(1, tmv_pkg::OFF_TRIG, 8'(e * 8 + 4));
      tick(40);
      apb(0, tmv_pkg::OFF_CNT, 0);
      chk(q, 0);
      fork
        pins.trigPulse();
      join_none
      if (e == 0)
      begin
        tick(40);
        chk(wave, 0);
      end
      else
      begin
        waitSig(0, 1);
        waitSig(0, 0);
        chk(c, 8);
      end
      tick(20);
      apb(0, tmv_pkg::OFF_CNT, 0);
      chk(q, 0);
    end
    apb(1, tmv_pkg::OFF_CTRL0, 0);
  endtask
  task automatic sExtClear();
    apb(1, tmv_pkg::OFF_TRIG, 0);
    apb(1, tmv_pkg::OFF_CNT, 0);
    apb(1, tmv_pkg::OFF_CTRL0, 8'h1d);
    pins.clocks(5);
    tick(4);
    apb(0, tmv_pkg::OFF_CNT, 0);
    chk(q, 5);
    pins.clearPulse();
    apb(0, tmv_pkg::OFF_CNT, 0);
    chk(q, 0);
  endtask
  initial
  begin
    tick(4);
    rst <= 1'b0;
    tick(1);
    sReset();
    sOverflow();
    sPeriodic();
    sTrigger();
    sExtClear();
    print_verdict();
  end
endmodule
